// file: design/mpmc_regs.svh
// Offsets, field positions, reset values and timing counts of the power and mode controller
`ifndef MPMC_REGS_SVH
`define MPMC_REGS_SVH
`define MPMC_ADDR_W          4
`define MPMC_REG_CTRL        4'h0
`define MPMC_REG_LED         4'h1
`define MPMC_REG_BAUD        4'h2
`define MPMC_REG_STATUS      4'h3
`define MPMC_REG_LINK        4'h4
`define MPMC_REG_PATTERN     4'h5
`define MPMC_REG_WDOG        4'h6
`define MPMC_CTRL_FLOW_BIT   0
`define MPMC_CTRL_MANUAL_BIT 1
`define MPMC_CTRL_SRST_BIT   2
`define MPMC_CTRL_KICK_BIT   3
`define MPMC_CTRL_RESET      32'h0000_0000
`define MPMC_LED_RESET       32'h0000_0008
`define MPMC_BAUD_RESET      32'h0000_0004
`define MPMC_CLK_HZ          10000000
`define MPMC_HH_MIN_MS       500
`define MPMC_HH_CYCLES       ((`MPMC_CLK_HZ / 1000) * `MPMC_HH_MIN_MS)
`define MPMC_FILT_LEN        4
`define MPMC_WDOG_CYCLES     1000000
`define MPMC_STEP_CYCLES     1000000
`endif

// file: design/mpmc_pkg.sv
// Types shared by the power and mode controller
package mpmc_pkg;
    typedef enum logic [1:0] {MPMC_BOOT_APP, MPMC_BOOT_TEST, MPMC_BOOT_OTHER} mpmc_boot_t;
    typedef enum logic [2:0] {
        MPMC_COND_STANDBY, MPMC_COND_LINKBACK, MPMC_COND_LOWBAT,
        MPMC_COND_INQUIRY, MPMC_COND_LINK, MPMC_COND_PAGE
    } mpmc_cond_t;
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mpmc_bus_t;
    typedef struct packed {
        logic button;
        logic wake_n;
        logic ext_rst_n;
    } mpmc_ctl_t;
endpackage : mpmc_pkg

// file: design/mpmc_filter.sv
// Two-stage synchroniser followed by a stable-level glitch filter
`timescale 1ns/1ps
`include "mpmc_regs.svh"
module mpmc_filter (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      level
);
    logic       s1_q, s2_q, lvl_q, lvl_d;
    logic [2:0] cnt_q, cnt_d;
    always_comb begin
        lvl_d = lvl_q;
        cnt_d = 3'h0;
        if (s2_q != lvl_q) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'(`MPMC_FILT_LEN - 1)) begin
                lvl_d = s2_q;
                cnt_d = 3'h0;
            end
        end
    end
    // Idle level high: all filtered pins are inactive high or pulled up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            lvl_q <= 1'b1;
            cnt_q <= 3'h0;
        end else begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
        end
    end
    assign level = lvl_q;
endmodule : mpmc_filter

// file: design/mpmc_lamp.sv
// Status lamp driver: 16-step brightness PWM gated by a per-condition flash pattern
`timescale 1ns/1ps
`include "mpmc_regs.svh"
module mpmc_lamp (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  bright,
    input  wire logic [7:0]  pattern,
    input  wire logic        enable,
    output logic             lamp_on
);
    logic [3:0]  pwm_q, pwm_d;
    logic [19:0] tick_q, tick_d;
    logic [2:0]  step_q, step_d;
    logic        on_q, on_d;
    always_comb begin
        pwm_d  = pwm_q + 4'h1;
        tick_d = tick_q + 20'h1;
        step_d = step_q;
        if (tick_q == 20'(`MPMC_STEP_CYCLES - 1)) begin
            tick_d = 20'h0;
            step_d = step_q + 3'h1;
        end
        // Brightness 0 is dark; 15 is on in 15 of 16 slots
        on_d = enable && pattern[step_q] && (pwm_q < bright);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_q  <= 4'h0;
            tick_q <= 20'h0;
            step_q <= 3'h0;
            on_q   <= 1'b0;
        end else begin
            pwm_q  <= pwm_d;
            tick_q <= tick_d;
            step_q <= step_d;
            on_q   <= on_d;
        end
    end
    assign lamp_on = on_q;
endmodule : mpmc_lamp

// file: design/mpmc_top.sv
// Power, boot mode, reset, status lamp and UART setting control of the serial module
`timescale 1ns/1ps
`include "mpmc_regs.svh"
// How it works
// - Strap A low, B and C high selects nonvolatile-write and test mode.
// - All three straps high selects normal application operation.
// - Straps are weakly pulled high so open pins select application mode.
// - Button high turns on, button low turns off into deepest off state.
// - In shutdown a low button level is ignored.
// - A low wake level leaves shutdown.
// - External reset low or power-on detect forces the power-on reset state.
// - A watchdog resets the whole chip when it expires.
// - Auto pattern resets by pin or watchdog only; manual pattern also by serial command.
// - Status lamp brightness has 16 steps.
// - Six lamp conditions each have their own configurable flash sequence.
// - Hardware flow control is off after reset until configuration enables it.
// - UART rate is selectable from 2400 to 921600 baud off 16 MHz.
// - Status pins: HH off at least 500ms, HL access, LH or LL link.
module mpmc_top
    import mpmc_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        POR_N,
    input  wire logic        STRAP_PIN_A,
    input  wire logic        STRAP_PIN_B,
    input  wire logic        STRAP_PIN_C,
    output logic [2:0]       STRAP_PULL_EN,
    input  wire logic        POWER_BUTTON_INPUT,
    input  wire logic        WAKE_N,
    input  wire logic        EXT_RST_N,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    input  wire logic        UART_RTS_IN,
    output logic             UART_CTS_OUT,
    output logic             UART_TX_BLOCK,
    output logic [3:0]       BAUD_SEL,
    output logic             DEEPEST_OFF_STATE,
    output logic             CHIP_RESET,
    output logic             TEST_MODE,
    output logic             STATUS_LAMP_OUT,
    output logic             STATUS_PIN_ONE,
    output logic             STATUS_PIN_TWO
);
    typedef enum logic [1:0] {ST_RESET, ST_OFF, ST_ACCESS, ST_LINK} mpmc_state_t;

    // Maps the three strap levels to a boot mode
    function automatic mpmc_boot_t decode_straps(input logic a, input logic b, input logic c);
        if (a && b && c)
            decode_straps = MPMC_BOOT_APP;
        else if (!a && b && c)
            decode_straps = MPMC_BOOT_TEST;
        else
            decode_straps = MPMC_BOOT_OTHER;
    endfunction : decode_straps

    localparam logic [23:0] HH_CYC   = 24'(`MPMC_HH_CYCLES);
    localparam logic [19:0] WDOG_CYC = 20'(`MPMC_WDOG_CYCLES);

    mpmc_bus_t  bus;
    mpmc_ctl_t  ctl;
    logic       button_f, wake_f, ext_rst_f;
    logic       hard_rst_n;
    logic       lamp_on;

    assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
    assign ctl = '{button: button_f, wake_n: wake_f, ext_rst_n: ext_rst_f};

    // Raw button pin is never acted on directly
    mpmc_filter u_btn (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .raw   (POWER_BUTTON_INPUT),
        .level (button_f)
    );

    // Wake is level sensitive, so a bounce must not leave shutdown
    mpmc_filter u_wake (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .raw   (WAKE_N),
        .level (wake_f)
    );

    // Not cleared by chip reset, else a held pin would release itself
    mpmc_filter u_rst (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .raw   (EXT_RST_N),
        .level (ext_rst_f)
    );

    // Registers
    logic [31:0] ctrl_q, ctrl_d;
    logic [7:0]  led_q, led_d;
    logic [3:0]  baud_q, baud_d;
    logic [2:0]  cond_q, cond_d;
    logic [1:0]  link_q, link_d;
    logic [7:0]  pat_q [0:5];
    logic [7:0]  pat_d [0:5];
    logic [31:0] rdata_q, rdata_d;
    // Power state
    mpmc_state_t st_q, st_d;
    logic [23:0] hh_q, hh_d;
    logic [19:0] wd_q, wd_d;
    logic        chip_rst_q, chip_rst_d;
    logic        test_q, test_d;
    logic        pin1_q, pin1_d, pin2_q, pin2_d;
    logic        cts_q, cts_d, txb_q, txb_d;
    logic        srst_cmd, kick;

    assign srst_cmd = bus.wr && bus.addr == `MPMC_REG_CTRL
                      && bus.wdata[`MPMC_CTRL_SRST_BIT]
                      && ctrl_q[`MPMC_CTRL_MANUAL_BIT];
    assign kick     = bus.wr && bus.addr == `MPMC_REG_CTRL && bus.wdata[`MPMC_CTRL_KICK_BIT];
    // Power-on detect, filtered pin, watchdog and serial command all reset the chip
    assign hard_rst_n = POR_N && ctl.ext_rst_n && !chip_rst_q;

    // Register file; settings fall back to defaults on any chip reset
    always_comb begin
        ctrl_d  = ctrl_q;
        led_d   = led_q;
        baud_d  = baud_q;
        cond_d  = cond_q;
        link_d  = link_q;
        pat_d   = pat_q;
        rdata_d = 32'h0;
        if (bus.wr) begin
            case (bus.addr)
                `MPMC_REG_CTRL: ctrl_d = {30'h0, bus.wdata[1:0]};
                `MPMC_REG_LED: begin
                    led_d[3:0] = bus.wdata[3:0];
                    if (bus.wdata[6:4] <= 3'h5)
                        cond_d = bus.wdata[6:4];
                end
                `MPMC_REG_BAUD: begin
                    if (bus.wdata[3:0] <= 4'hc)
                        baud_d = bus.wdata[3:0];
                end
                `MPMC_REG_LINK: link_d = bus.wdata[1:0];
                `MPMC_REG_PATTERN: begin
                    if (bus.wdata[10:8] <= 3'h5)
                        pat_d[bus.wdata[10:8]] = bus.wdata[7:0];
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                `MPMC_REG_CTRL:    rdata_d = ctrl_q;
                `MPMC_REG_LED:     rdata_d = {25'h0, cond_q, led_q[3:0]};
                `MPMC_REG_BAUD:    rdata_d = {28'h0, baud_q};
                `MPMC_REG_STATUS:  rdata_d = {24'h0, test_q, ctl.wake_n, ctl.button,
                                              pin1_q, pin2_q, 1'b0, st_q};
                `MPMC_REG_LINK:    rdata_d = {30'h0, link_q};
                `MPMC_REG_PATTERN: rdata_d = {24'h0, pat_q[cond_q]};
                `MPMC_REG_WDOG:    rdata_d = {12'h0, wd_q};
                default:           rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || !hard_rst_n) begin
            ctrl_q  <= `MPMC_CTRL_RESET;
            led_q   <= 8'(`MPMC_LED_RESET);
            baud_q  <= 4'(`MPMC_BAUD_RESET);
            cond_q  <= 3'h0;
            link_q  <= 2'h0;
            pat_q   <= '{8'h0f, 8'haa, 8'h01, 8'h55, 8'hff, 8'h33};
            rdata_q <= 32'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            led_q   <= led_d;
            baud_q  <= baud_d;
            cond_q  <= cond_d;
            link_q  <= link_d;
            pat_q   <= pat_d;
            rdata_q <= rdata_d;
        end
    end

    // Power state, watchdog and status pins
    always_comb begin
        st_d       = st_q;
        hh_d       = hh_q;
        wd_d       = wd_q + 20'h1;
        chip_rst_d = 1'b0;
        test_d     = test_q;
        case (st_q)
            ST_RESET: begin
                // Straps sampled every cycle while in the reset state; the last sample holds after it
                test_d = decode_straps(STRAP_PIN_A, STRAP_PIN_B, STRAP_PIN_C)
                         == MPMC_BOOT_TEST;
                hh_d   = hh_q + 24'h1;
                if (hh_q >= HH_CYC - 24'h1)
                    st_d = ctl.button ? ST_ACCESS : ST_OFF;
            end
            ST_OFF: begin
                hh_d = 24'h0;
                wd_d = 20'h0;
                // Low button is meaningless here; wake or a high button restarts
                if (!ctl.wake_n || ctl.button)
                    st_d = ST_RESET;
            end
            ST_ACCESS, ST_LINK: begin
                hh_d = 24'h0;
                if (!ctl.button)
                    st_d = ST_OFF;
                else if (link_q[1])
                    st_d = ST_LINK;
                else
                    st_d = ST_ACCESS;
            end
            default: st_d = ST_RESET;
        endcase
        if (kick || st_q == ST_OFF)
            wd_d = 20'h0;
        if (wd_q == WDOG_CYC - 20'h1 || srst_cmd)
            chip_rst_d = 1'b1;
        case (st_d)
            ST_ACCESS: begin
                pin1_d = 1'b1;
                pin2_d = 1'b0;
            end
            ST_LINK: begin
                pin1_d = 1'b0;
                pin2_d = !link_q[0];
            end
            default: begin
                pin1_d = 1'b1;
                pin2_d = 1'b1;
            end
        endcase
        // Flow control only once enabled; until then CTS stays asserted low
        cts_d = !ctrl_q[`MPMC_CTRL_FLOW_BIT] ? 1'b0 : (st_d == ST_OFF);
        txb_d = ctrl_q[`MPMC_CTRL_FLOW_BIT] && UART_RTS_IN;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || !hard_rst_n) begin
            st_q       <= ST_RESET;
            hh_q       <= 24'h0;
            wd_q       <= 20'h0;
            chip_rst_q <= 1'b0;
            test_q     <= 1'b0;
            pin1_q     <= 1'b1;
            pin2_q     <= 1'b1;
            cts_q      <= 1'b0;
            txb_q      <= 1'b0;
        end else begin
            st_q       <= st_d;
            hh_q       <= hh_d;
            wd_q       <= wd_d;
            chip_rst_q <= chip_rst_d;
            test_q     <= test_d;
            pin1_q     <= pin1_d;
            pin2_q     <= pin2_d;
            cts_q      <= cts_d;
            txb_q      <= txb_d;
        end
    end

    mpmc_lamp u_lamp (
        .clk     (SYS_CLK),
        .rst_n   (RST_N && hard_rst_n),
        .bright  (led_q[3:0]),
        .pattern (pat_q[cond_q]),
        .enable  (st_q == ST_ACCESS || st_q == ST_LINK),
        .lamp_on (lamp_on)
    );

    // Output flops; pull enables stay on, so open straps read high
    logic off_q, rst_out_q, pull_q;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            off_q     <= 1'b0;
            rst_out_q <= 1'b1;
            pull_q    <= 1'b1;
        end else begin
            off_q     <= st_q == ST_OFF;
            rst_out_q <= !hard_rst_n;
            pull_q    <= 1'b1;
        end
    end

    assign REG_RDATA         = rdata_q;
    assign UART_CTS_OUT      = cts_q;
    assign UART_TX_BLOCK     = txb_q;
    assign BAUD_SEL          = baud_q;
    assign DEEPEST_OFF_STATE = off_q;
    assign CHIP_RESET        = rst_out_q;
    assign TEST_MODE         = test_q;
    assign STATUS_LAMP_OUT   = lamp_on;
    assign STATUS_PIN_ONE    = pin1_q;
    assign STATUS_PIN_TWO    = pin2_q;
    assign STRAP_PULL_EN     = {3{pull_q}};
endmodule : mpmc_top

// file: sim/mpmc_host.sv
// Host-side model: strap drivers with pull resolution and flow-control ready line
`timescale 1ns/1ps
module mpmc_host (
    input  wire logic [2:0] drv_en,
    input  wire logic [2:0] drv_val,
    input  wire logic [2:0] pull_en,
    input  wire logic       busy,
    output logic      [2:0] strap,
    output logic            rts
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // Unpulled released pin shows the inverse, never a stale level
            strap[i] = drv_en[i] ? drv_val[i] : (pull_en[i] ? 1'b1 : ~drv_val[i]);
        end
    end
    assign rts = busy;
endmodule : mpmc_host

// file: sim/mpmc_checker.sv
// Port-level assertions of the power and mode controller
`timescale 1ns/1ps
`include "mpmc_regs.svh"
module mpmc_checker (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        POR_N,
    input wire logic        POWER_BUTTON_INPUT,
    input wire logic        WAKE_N,
    input wire logic        EXT_RST_N,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        UART_RTS_IN,
    input wire logic        UART_CTS_OUT,
    input wire logic        UART_TX_BLOCK,
    input wire logic [3:0]  BAUD_SEL,
    input wire logic        DEEPEST_OFF_STATE,
    input wire logic        CHIP_RESET,
    input wire logic [2:0]  STRAP_PULL_EN,
    input wire logic        STATUS_PIN_ONE,
    input wire logic        STATUS_PIN_TWO
);
    logic [31:0] hh_q, hh_d, wd_q, wd_d;
    logic [3:0]  qt_q, qt_d;
    logic        hh, kick, quiet;
    assign hh = STATUS_PIN_ONE && STATUS_PIN_TWO;
    assign kick = REG_WR && REG_ADDR == `MPMC_REG_CTRL && REG_WDATA[`MPMC_CTRL_KICK_BIT];
    assign quiet = !POWER_BUTTON_INPUT && WAKE_N && EXT_RST_N && POR_N && !REG_WR;
    always_comb begin
        hh_d = hh ? hh_q + 32'h1 : 32'h0;
        // Restart on any HH phase: lenient, as the off state does not count but the reset state does
        wd_d = (hh || kick || CHIP_RESET) ? 32'h0 : wd_q + 32'h1;
        qt_d = !quiet ? 4'h0 : (qt_q == 4'hf ? qt_q : qt_q + 4'h1);
    end
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            hh_q <= 32'h0;
            wd_q <= 32'h0;
            qt_q <= 4'h0;
        end else begin
            hh_q <= hh_d;
            wd_q <= wd_d;
            qt_q <= qt_d;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    AST_PULL_UP: assert property (disable iff (1'b0)
        !RST_N |=> STRAP_PULL_EN == 3'h7) else $error("strap pulls not enabled");
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !RST_N |=> CHIP_RESET && hh) else $error("reset state not shown");
    AST_FLOW_OFF: assert property (disable iff (1'b0)
        !RST_N |=> !UART_CTS_OUT && !UART_TX_BLOCK) else $error("flow control on after reset");
    AST_FLOW_RTS: assert property (
        UART_TX_BLOCK |-> $past(UART_RTS_IN)) else $error("tx blocked without host request");
    AST_BAUD: assert property (
        BAUD_SEL <= 4'hc) else $error("rate index out of table");
    AST_HH_MIN: assert property (
        $fell(hh) |-> hh_q >= `MPMC_HH_CYCLES - 2) else $error("HH status too short");
    AST_OFF_HOLD: assert property (
        qt_q >= 4'ha && DEEPEST_OFF_STATE |=> DEEPEST_OFF_STATE) else $error("off state left");
    AST_WAKE: assert property (
        (DEEPEST_OFF_STATE && !WAKE_N) [*8] |-> ##[0:3] !DEEPEST_OFF_STATE)
        else $error("wake ignored");
    AST_EXT_RST: assert property (
        $fell(EXT_RST_N) ##1 (!EXT_RST_N) [*7] |-> ##[0:3] CHIP_RESET)
        else $error("external reset ignored");
    AST_POR: assert property (
        $fell(POR_N) |-> ##[1:3] CHIP_RESET) else $error("power-on detect ignored");
    AST_WDOG: assert property (
        wd_q <= `MPMC_WDOG_CYCLES + 8) else $error("watchdog did not reset chip");
endmodule : mpmc_checker
bind mpmc_top mpmc_checker u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .POR_N(POR_N),
    .POWER_BUTTON_INPUT(POWER_BUTTON_INPUT), .WAKE_N(WAKE_N), .EXT_RST_N(EXT_RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .UART_RTS_IN(UART_RTS_IN),
    .UART_CTS_OUT(UART_CTS_OUT), .UART_TX_BLOCK(UART_TX_BLOCK), .BAUD_SEL(BAUD_SEL),
    .DEEPEST_OFF_STATE(DEEPEST_OFF_STATE), .CHIP_RESET(CHIP_RESET),
    .STRAP_PULL_EN(STRAP_PULL_EN), .STATUS_PIN_ONE(STATUS_PIN_ONE),
    .STATUS_PIN_TWO(STATUS_PIN_TWO));

// file: sim/tb_top.sv
// Self-checking bench for the power and mode controller
`timescale 1ns/1ps
`include "mpmc_regs.svh"
module tb_top;
    logic        SYS_CLK = 1'b0, RST_N = 1'b0, POR_N = 1'b1, WAKE_N = 1'b1, EXT_RST_N = 1'b1;
    logic        POWER_BUTTON_INPUT = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, busy = 1'b1, seen;
    logic [3:0]  REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h0, rv;
    logic [2:0]  s_en = 3'h7, s_val = 3'h7;
    wire         STRAP_PIN_A, STRAP_PIN_B, STRAP_PIN_C, UART_RTS_IN, UART_CTS_OUT;
    wire         UART_TX_BLOCK, DEEPEST_OFF_STATE, CHIP_RESET, TEST_MODE, STATUS_LAMP_OUT;
    wire         STATUS_PIN_ONE, STATUS_PIN_TWO;
    wire [2:0]   STRAP_PULL_EN;
    wire [3:0]   BAUD_SEL;
    wire [31:0]  REG_RDATA;
    int          bad_count = 0, n_checks = 0;
    mpmc_top u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .POR_N(POR_N),
        .STRAP_PIN_A(STRAP_PIN_A), .STRAP_PIN_B(STRAP_PIN_B), .STRAP_PIN_C(STRAP_PIN_C),
        .STRAP_PULL_EN(STRAP_PULL_EN), .POWER_BUTTON_INPUT(POWER_BUTTON_INPUT),
        .WAKE_N(WAKE_N), .EXT_RST_N(EXT_RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .UART_RTS_IN(UART_RTS_IN),
        .UART_CTS_OUT(UART_CTS_OUT), .UART_TX_BLOCK(UART_TX_BLOCK), .BAUD_SEL(BAUD_SEL),
        .DEEPEST_OFF_STATE(DEEPEST_OFF_STATE), .CHIP_RESET(CHIP_RESET), .TEST_MODE(TEST_MODE),
        .STATUS_LAMP_OUT(STATUS_LAMP_OUT), .STATUS_PIN_ONE(STATUS_PIN_ONE),
        .STATUS_PIN_TWO(STATUS_PIN_TWO));
    mpmc_host u_host (.drv_en(s_en), .drv_val(s_val), .pull_en(STRAP_PULL_EN), .busy(busy),
        .strap({STRAP_PIN_A, STRAP_PIN_B, STRAP_PIN_C}), .rts(UART_RTS_IN));
    initial forever #50 SYS_CLK = ~SYS_CLK;
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 rv = REG_RDATA;
    endtask : rd
    task automatic wait_rst(input logic v, input int n);
        for (int i = 0; i < n && CHIP_RESET !== v; i++) cyc(1);
        chk(CHIP_RESET, v);
    endtask : wait_rst
    task automatic t_reset();
        chk(STRAP_PULL_EN, 3'h7);
        chk({STATUS_PIN_ONE, STATUS_PIN_TWO, UART_CTS_OUT, UART_TX_BLOCK}, 4'hc);
        chk(BAUD_SEL, 4'h4);
        chk(DEEPEST_OFF_STATE, 1'b0);
        chk(STATUS_LAMP_OUT, 1'b0);
        rd(`MPMC_REG_CTRL);
        chk(rv, `MPMC_CTRL_RESET);
        rd(`MPMC_REG_LED);
        chk(rv, `MPMC_LED_RESET);
        rd(`MPMC_REG_STATUS);
        chk(rv & 32'h9f, 32'h18);
        for (int a = 7; a < 16; a++) begin
            wr(4'(a), 32'hffff_ffff);
            rd(4'(a));
            chk(rv, 32'h0);
        end
        cyc(1);
        chk(REG_RDATA, 32'h0);
    endtask : t_reset
    task automatic t_straps();
        logic [3:0] tbl [3] = '{4'h7, 4'he, 4'h2};
        foreach (tbl[i]) begin
            @(posedge SYS_CLK);
            s_val <= tbl[i][3:1];
            cyc(6);
            chk(TEST_MODE, tbl[i][0]);
        end
        @(posedge SYS_CLK);
        s_en <= 3'h0;
        cyc(6);
        chk({STRAP_PIN_A, STRAP_PIN_B, STRAP_PIN_C, TEST_MODE}, 4'he);
        @(posedge SYS_CLK);
        s_en <= 3'h7;
        s_val <= 3'h7;
    endtask : t_straps
    task automatic t_baud();
        for (int i = 0; i < 15; i++) begin
            wr(`MPMC_REG_BAUD, i);
            cyc(2);
            chk(BAUD_SEL, i > 12 ? 12 : i);
        end
        wr(`MPMC_REG_BAUD, 32'h4);
    endtask : t_baud
    task automatic t_flow();
        chk(UART_TX_BLOCK, 1'b0);
        wr(`MPMC_REG_CTRL, 32'h1);
        cyc(2);
        chk(UART_TX_BLOCK, 1'b1);
        @(posedge SYS_CLK);
        busy <= 1'b0;
        cyc(3);
        chk(UART_TX_BLOCK, 1'b0);
        wr(`MPMC_REG_CTRL, 32'h0);
        @(posedge SYS_CLK);
        busy <= 1'b1;
        cyc(3);
        chk(UART_TX_BLOCK, 1'b0);
    endtask : t_flow
    task automatic t_lamp();
        for (int b = 0; b < 16; b++) begin
            wr(`MPMC_REG_LED, b);
            rd(`MPMC_REG_LED);
            chk(rv[3:0], b);
        end
        for (int c = 0; c < 6; c++) wr(`MPMC_REG_PATTERN, (c << 8) | (17 * (c + 1)));
        for (int c = 0; c < 6; c++) begin
            wr(`MPMC_REG_LED, (c << 4) | 8);
            rd(`MPMC_REG_PATTERN);
            chk(rv[7:0], 17 * (c + 1));
        end
        wr(`MPMC_REG_LED, 32'h68);
        rd(`MPMC_REG_LED);
        chk(rv[6:4], 3'h5);
        wr(`MPMC_REG_LED, 32'h8);
    endtask : t_lamp
    task automatic t_srst();
        wr(`MPMC_REG_BAUD, 32'h2);
        wr(`MPMC_REG_CTRL, 32'h4);
        cyc(6);
        chk({CHIP_RESET, BAUD_SEL}, 5'h2);
        wr(`MPMC_REG_CTRL, 32'h2);
        wr(`MPMC_REG_CTRL, 32'h6);
        wait_rst(1'b1, 4);
        wait_rst(1'b0, 30);
        rd(`MPMC_REG_CTRL);
        chk(rv, `MPMC_CTRL_RESET);
        chk(BAUD_SEL, 4'h4);
    endtask : t_srst
    task automatic t_pins();
        wr(`MPMC_REG_BAUD, 32'h1);
        @(posedge SYS_CLK);
        EXT_RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        EXT_RST_N <= 1'b1;
        seen = 1'b0;
        for (int i = 0; i < 12; i++) begin
            cyc(1);
            seen = seen | CHIP_RESET;
        end
        chk({seen, BAUD_SEL}, 5'h1);
        @(posedge SYS_CLK);
        EXT_RST_N <= 1'b0;
        wait_rst(1'b1, 12);
        @(posedge SYS_CLK);
        EXT_RST_N <= 1'b1;
        wait_rst(1'b0, 30);
        chk(BAUD_SEL, 4'h4);
        wr(`MPMC_REG_BAUD, 32'h1);
        @(posedge SYS_CLK);
        POR_N <= 1'b0;
        wait_rst(1'b1, 4);
        @(posedge SYS_CLK);
        POR_N <= 1'b1;
        wait_rst(1'b0, 30);
        chk(BAUD_SEL, 4'h4);
    endtask : t_pins
    initial begin
        repeat (4) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        cyc(8);
        t_reset();
        t_straps();
        t_baud();
        t_flow();
        t_lamp();
        t_srst();
        t_pins();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        test_done();
    end
endmodule : tb_top
